// file: rtl/isasr_pkg.sv
// Package for the slave address and status register block.
// Assumes a 32-bit word register port with byte offsets.
package isasr_pkg;
  localparam logic [7:0] OFF_DATA  = 8'h0c;
  localparam logic [7:0] OFF_OWN_PRI = 8'h10;
  localparam logic [7:0] OFF_STAT    = 8'h14;
  localparam logic [7:0] OFF_OWN_SEC = 8'h20;
  localparam logic [7:0] OFF_OWN_THR = 8'h24;
  localparam logic [7:0] OFF_MATCH = 8'h28;
  localparam logic [7:0] OFF_CTRL  = 8'h30;
  localparam logic [7:0] STAT_IDLE = 8'hf8;
  localparam logic [7:0] RST_BYTE  = 8'h00;
  localparam logic [6:0] BCAST_ADDR  = 7'h00;
  localparam int         CTRL_ACK_EN = 2;
  localparam int         CTRL_SI   = 3;
  localparam int         NUM_ADDR  = 3;

  // Events reported by the bus engine
  typedef struct packed {
    logic       start_seen;  // START or repeated START seen
    logic       stop_seen;   // STOP condition
    logic       addr_valid;  // First byte after START complete
    logic [6:0] addr;        // Received device address
    logic       rx_valid;    // Data byte received
    logic [7:0] rx_byte;
    logic       state_valid; // Bus engine entered a new state
    logic [7:0] state_code;
    logic       is_master;
  } isasr_bus_ev_s;

  // Software register port
  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } isasr_reg_req_s;
endpackage : isasr_pkg

// file: rtl/isasr_addr_cmp.sv
// One slave address comparator.
// Assumes address and field are stable in the compare cycle.
`timescale 1ns/1ps
module isasr_addr_cmp (
  input  wire logic [6:0] own_in,
  input  wire logic [6:0] rx_in,
  output logic            hit_out
);
  // Plain equality on the seven address bits
  assign hit_out = (own_in == rx_in);
endmodule : isasr_addr_cmp

// file: rtl/isasr_regs.sv
// Register side of an I2C controller: data, status, own addresses, match.
// Assumes a bus engine that reports events one cycle long and obeys hold.
`timescale 1ns/1ps
module isasr_regs (
  input  wire logic                     core_clk_in,
  input  wire logic                     resetn_in,
  input  wire isasr_pkg::isasr_reg_req_s req_in,
  output logic [31:0]                   rdata_out,
  input  wire isasr_pkg::isasr_bus_ev_s  ev_in,
  output logic [7:0]                    tx_byte_out,
  output logic                          tx_load_out,
  output logic                          scl_hold_out,
  output logic                          ack_bit_out,
  output logic                          addr_ack_out,
  output logic                          bcast_mode_out,
  output logic                          irq_out
);
  typedef enum logic [1:0] {
    ISASR_IDLE = 2'b01,
    ISASR_BUSY = 2'b10
  } isasr_mode_e;

  typedef struct packed {
    logic [7:0]  data;
    logic [7:0]  stat;
    logic [7:0]  own_pri;
    logic [6:0]  own_sec;
    logic [6:0]  own_thr;
    logic [2:0]  match;
    logic        ack_en;
    logic        si;
    logic [31:0] rdata;
    logic        tx_load;
    logic        addr_ack;
    logic        bcast;
    isasr_mode_e mode;
  } isasr_state_s;

  isasr_state_s st_q;
  isasr_state_s st_d;
  logic [2:0]   hit;
  logic [6:0]   own [3];
  logic         slave_ok;
  logic         bcast_hit;

  assign own[0] = st_q.own_pri[7:1];
  assign own[1] = st_q.own_sec;
  assign own[2] = st_q.own_thr;

  genvar g;
  generate
    for (g = 0; g < isasr_pkg::NUM_ADDR; g++) begin : g_cmp
      isasr_addr_cmp u_cmp (
        .own_in  (own[g]),
        .rx_in   (ev_in.addr),
        .hit_out (hit[g])
      );
    end
  endgenerate

  assign slave_ok = ev_in.addr_valid & ~ev_in.is_master;
  assign bcast_hit = st_q.own_pri[0] &
                     (ev_in.addr == isasr_pkg::BCAST_ADDR);

  // Next state; hardware sets win over software clears
  always_comb begin
    st_d          = st_q;
    st_d.tx_load  = 1'b0;
    st_d.addr_ack = 1'b0;
    st_d.rdata    = '0;
    // Register writes; only live bits kept
    if (req_in.wr) begin
      case (req_in.addr)
        isasr_pkg::OFF_DATA: begin
          st_d.data    = req_in.wdata[7:0];
          st_d.tx_load = 1'b1;
        end
        isasr_pkg::OFF_OWN_PRI: st_d.own_pri = req_in.wdata[7:0];
        isasr_pkg::OFF_OWN_SEC: st_d.own_sec = req_in.wdata[7:1];
        isasr_pkg::OFF_OWN_THR: st_d.own_thr = req_in.wdata[7:1];
        isasr_pkg::OFF_CTRL: begin
          st_d.ack_en = req_in.wdata[isasr_pkg::CTRL_ACK_EN];
          // Writing zero clears the flag
          if (!req_in.wdata[isasr_pkg::CTRL_SI]) begin
            st_d.si = 1'b0;
          end
        end
        default: ;
      endcase
    end
    // Register reads, data one cycle later
    if (req_in.rd) begin
      case (req_in.addr)
        isasr_pkg::OFF_DATA:  st_d.rdata[7:0] = st_q.data;
        isasr_pkg::OFF_OWN_PRI: st_d.rdata[7:0] = st_q.own_pri;
        isasr_pkg::OFF_STAT:    st_d.rdata[7:0] = st_q.stat;
        isasr_pkg::OFF_OWN_SEC: st_d.rdata[7:1] = st_q.own_sec;
        isasr_pkg::OFF_OWN_THR: st_d.rdata[7:1] = st_q.own_thr;
        isasr_pkg::OFF_MATCH:   st_d.rdata[2:0] = st_q.match;
        isasr_pkg::OFF_CTRL: begin
          st_d.rdata[isasr_pkg::CTRL_ACK_EN] = st_q.ack_en;
          st_d.rdata[isasr_pkg::CTRL_SI] = st_q.si;
        end
        default: ;
      endcase
    end
    if (ev_in.rx_valid) begin
      st_d.data = ev_in.rx_byte;
    end
    if (ev_in.state_valid) begin
      st_d.stat = ev_in.state_code;
      if (ev_in.state_code != isasr_pkg::STAT_IDLE) begin
        st_d.si = 1'b1;
      end else begin
        st_d.si = 1'b0;
      end
    end
    // flags cleared on START or STOP
    if (ev_in.start_seen | ev_in.stop_seen) begin
      st_d.match = '0;
      st_d.bcast = 1'b0;
    end
    if (slave_ok) begin
      // Built on the cleared value so a same-cycle START keeps only new hits
      st_d.match = st_d.match | hit;
      if (st_q.ack_en && (hit != '0 || bcast_hit)) begin
        st_d.addr_ack = 1'b1;
      end
      if (st_q.ack_en && bcast_hit) begin
        st_d.bcast = 1'b1;
      end
    end
    // Coarse activity tracking between START and STOP
    case (st_q.mode)
      ISASR_IDLE: if (ev_in.start_seen) st_d.mode = ISASR_BUSY;
      ISASR_BUSY: if (ev_in.stop_seen) st_d.mode = ISASR_IDLE;
      default:    st_d.mode = ISASR_IDLE;
    endcase
  end

  // State register with synchronous reset
  always_ff @(posedge core_clk_in) begin
    if (!resetn_in) begin
      st_q       <= '0;
      st_q.stat  <= isasr_pkg::STAT_IDLE;
      st_q.data  <= isasr_pkg::RST_BYTE;
      st_q.mode  <= ISASR_IDLE;
    end else begin
      st_q <= st_d;
    end
  end

  // Outputs straight from the state flops
  assign rdata_out      = st_q.rdata;
  assign tx_byte_out    = st_q.data;
  assign tx_load_out    = st_q.tx_load;
  assign scl_hold_out   = st_q.si;
  assign ack_bit_out    = st_q.ack_en;
  assign addr_ack_out   = st_q.addr_ack;
  assign bcast_mode_out = st_q.bcast;
  assign irq_out        = st_q.si;

  // All checks run on the one core clock and sleep during reset
  default clocking cb_chk @(posedge core_clk_in);
  endclocking
  default disable iff (!resetn_in);

  // Named single-cycle steps that the checks below are built from

  // Software reads the data register
  sequence s_data_rd;
    req_in.rd && (req_in.addr == isasr_pkg::OFF_DATA);
  endsequence

  // Software reads the match flags
  sequence s_match_rd;
    req_in.rd && (req_in.addr == isasr_pkg::OFF_MATCH);
  endsequence

  // Software writes the control word
  sequence s_ctrl_wr;
    req_in.wr && (req_in.addr == isasr_pkg::OFF_CTRL);
  endsequence

  // Software tries to write the read-only status code
  sequence s_stat_wr;
    req_in.wr && (req_in.addr == isasr_pkg::OFF_STAT) &&
      !ev_in.state_valid;
  endsequence

  // Software writes the data register with no received byte alongside
  sequence s_data_wr;
    req_in.wr && (req_in.addr == isasr_pkg::OFF_DATA) && !ev_in.rx_valid;
  endsequence

  // Slave-mode address that hits one of the own addresses
  sequence s_slave_hit;
    slave_ok && st_q.ack_en && (hit != '0);
  endsequence

  // Broadcast address accepted in slave mode
  sequence s_bcast_take;
    slave_ok && st_q.ack_en && bcast_hit;
  endsequence

  // Any slave-mode address seen while answers are switched off and broadcast mode is clear
  sequence s_bcast_skip;
    slave_ok && !st_q.ack_en && !bcast_mode_out;
  endsequence

  // Address seen in master mode with no START or STOP alongside
  sequence s_master_addr;
    ev_in.addr_valid && ev_in.is_master &&
      !ev_in.start_seen && !ev_in.stop_seen;
  endsequence

  // Flag left alone: no clearing write and no new bus state
  sequence s_flag_keep;
    irq_out && !ev_in.state_valid &&
      !(req_in.wr && (req_in.addr == isasr_pkg::OFF_CTRL) &&
        !req_in.wdata[isasr_pkg::CTRL_SI]);
  endsequence

  // idle code never shows a pending flag
  idle_flag_a: assert property (
    ev_in.state_valid && ev_in.state_code == isasr_pkg::STAT_IDLE
    |=> !irq_out) else $error("flag set on idle code");

  state_flag_a: assert property (
    ev_in.state_valid && ev_in.state_code != isasr_pkg::STAT_IDLE
    |=> irq_out && scl_hold_out) else $error("flag not raised");

  stat_ro_a: assert property (
    s_stat_wr |=> st_q.stat == $past(st_q.stat))
    else $error("status code written");

  match_clear_a: assert property (
    (ev_in.start_seen || ev_in.stop_seen) && !slave_ok
    |=> st_q.match == '0) else $error("match not cleared");

  master_ign_a: assert property (
    ev_in.addr_valid && ev_in.is_master |=> !addr_ack_out)
    else $error("ack in master mode");

  // master mode leaves the match flags alone
  master_keep_a: assert property (
    s_master_addr |=> st_q.match == $past(st_q.match))
    else $error("match moved in master mode");

  ack_gate_a: assert property (
    addr_ack_out |-> $past(st_q.ack_en)) else $error("ack without enable");

  // a hit with enable is answered one cycle later
  addr_ack_a: assert property (
    s_slave_hit |=> addr_ack_out) else $error("address not answered");

  match_set_a: assert property (
    slave_ok && hit[0] |=> st_q.match[0]) else $error("match 0 lost");

  // second address flag follows its comparator
  match_sec_a: assert property (
    slave_ok && hit[1] |=> st_q.match[1]) else $error("match 1 lost");

  // third address flag follows its comparator
  match_thr_a: assert property (
    slave_ok && hit[2] |=> st_q.match[2]) else $error("match 2 lost");

  bcast_set_a: assert property (
    s_bcast_take |=> bcast_mode_out) else $error("broadcast not taken");

  // broadcast ignored while answers are off
  bcast_skip_a: assert property (
    s_bcast_skip |=> !bcast_mode_out) else $error("broadcast taken");

  // flag and clock hold stay until software or the idle status code clears them
  flag_keep_a: assert property (
    s_flag_keep |=> irq_out && scl_hold_out) else $error("flag dropped");

  // response bit follows the last control write
  ack_bit_a: assert property (
    s_ctrl_wr |=> ack_bit_out == $past(req_in.wdata[isasr_pkg::CTRL_ACK_EN]))
    else $error("response bit wrong");

  tx_write_a: assert property (
    s_data_wr
    |=> tx_load_out && tx_byte_out == $past(req_in.wdata[7:0]))
    else $error("tx byte wrong");

  rx_show_a: assert property (
    ev_in.rx_valid |=> tx_byte_out == $past(ev_in.rx_byte))
    else $error("rx byte wrong");

  rsv_zero_a: assert property (
    s_match_rd |=> rdata_out[31:3] == '0) else $error("reserved bits set");

  rsv_data_a: assert property (
    s_data_rd |=> rdata_out[31:8] == '0) else $error("data bits set");

  // read data is zero outside the answer cycle
  rd_quiet_a: assert property (
    !req_in.rd |=> rdata_out == '0) else $error("stray read data");
endmodule : isasr_regs

// file: tb/isasr_bus_model.sv
// Bus engine stand-in feeding events to the register block.
// Assumes the block samples events on the rising clock edge.
`timescale 1ns/1ps
module isasr_bus_model (
  input  wire logic               clk_in,
  input  wire logic               hold_in,
  output isasr_pkg::isasr_bus_ev_s ev_out
);
  initial ev_out = '0;

  // One-cycle event; idle fields are inverted so stale data never matches
  task automatic ev_pulse(input isasr_pkg::isasr_bus_ev_s e);
    isasr_pkg::isasr_bus_ev_s r;
    r = ~e;
    r.start_seen = 1'b0;
    r.stop_seen = 1'b0;
    r.addr_valid = 1'b0;
    r.rx_valid = 1'b0;
    r.state_valid = 1'b0;
    r.is_master = e.is_master;
    while (hold_in && !e.state_valid) @(posedge clk_in);
    @(posedge clk_in);
    ev_out <= e;
    @(posedge clk_in);
    ev_out <= r;
  endtask : ev_pulse
endmodule : isasr_bus_model

// file: tb/tb_top.sv
// Self-checking bench for the address and status register block.
// Assumes the bus model file and the design package are compiled first.
`timescale 1ns/1ps
module tb_top;
  logic                      core_clk_in = 1'b0;
  logic                      resetn_in = 1'b0;
  isasr_pkg::isasr_reg_req_s req = '0;
  isasr_pkg::isasr_bus_ev_s  ev;
  logic [31:0]               rdata;
  logic [7:0]                tx_byte;
  logic                      tx_load, hold, ack_bit, addr_ack, bcast, irq;
  int                        err_total = 0;
  int                        tests_run = 0;

  always #10 core_clk_in = ~core_clk_in;

  isasr_regs u_dut (.core_clk_in(core_clk_in), .resetn_in(resetn_in),
    .req_in(req), .rdata_out(rdata), .ev_in(ev), .tx_byte_out(tx_byte),
    .tx_load_out(tx_load), .scl_hold_out(hold), .ack_bit_out(ack_bit),
    .addr_ack_out(addr_ack), .bcast_mode_out(bcast), .irq_out(irq));
  isasr_bus_model u_bus (.clk_in(core_clk_in), .hold_in(hold), .ev_out(ev));

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : report_and_stop

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk_word

  task automatic chk_bit(input logic got, input logic exp);
    chk_word({31'h0, got}, {31'h0, exp});
  endtask : chk_bit

  // Register writes and reads; settle 1 ns past the taking edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk_in);
    req <= '{a, d, 1'b1, 1'b0};
    @(posedge core_clk_in);
    req.wr <= 1'b0;
    #1;
  endtask : wr

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    @(posedge core_clk_in);
    req <= '{a, 32'h0, 1'b0, 1'b1};
    @(posedge core_clk_in);
    req.rd <= 1'b0;
    #1;
    chk_word(rdata, exp);
  endtask : rd_chk

  // Kinds: 0 address, 1 start, 2 stop, 3 rx byte, 4 state code
  task automatic send(input int k, input logic [7:0] v, input logic m);
    isasr_pkg::isasr_bus_ev_s e;
    e = '0;
    e.is_master = m;
    e.addr_valid = (k == 0);
    e.addr = v[6:0];
    e.start_seen = (k == 1);
    e.stop_seen = (k == 2);
    e.rx_valid = (k == 3);
    e.rx_byte = v;
    e.state_valid = (k == 4);
    e.state_code = v;
    u_bus.ev_pulse(e);
    #1;
  endtask : send

  initial begin
    logic [7:0] offs [7];
    offs = '{8'h0c, 8'h10, 8'h14, 8'h20, 8'h24, 8'h28, 8'h04};
    repeat (8) @(posedge core_clk_in);
    resetn_in <= 1'b1;
    for (int i = 0; i < 7; i++) begin
      rd_chk(offs[i], (i == 2) ? 32'hf8 : 32'h0);
    end
    $display("test reset done");
    wr(isasr_pkg::OFF_OWN_PRI, 32'hffff_ffa5);
    rd_chk(isasr_pkg::OFF_OWN_PRI, 32'ha5);
    wr(isasr_pkg::OFF_OWN_SEC, 32'hffff_ffff);
    rd_chk(isasr_pkg::OFF_OWN_SEC, 32'hfe);
    wr(isasr_pkg::OFF_OWN_THR, 32'h67);
    rd_chk(isasr_pkg::OFF_OWN_THR, 32'h66);
    wr(isasr_pkg::OFF_STAT, 32'h0);
    rd_chk(isasr_pkg::OFF_STAT, 32'hf8);
    wr(isasr_pkg::OFF_DATA, 32'h1234_5678);
    chk_bit(tx_load, 1'b1);
    chk_word({24'h0, tx_byte}, 32'h78);
    rd_chk(isasr_pkg::OFF_DATA, 32'h78);
    $display("test regs done");
    wr(isasr_pkg::OFF_CTRL, 32'h4);
    chk_bit(ack_bit, 1'b1);
    send(0, 8'h52, 1'b0);
    chk_bit(addr_ack, 1'b1);
    send(0, 8'h7f, 1'b0);
    chk_bit(addr_ack, 1'b1);
    send(0, 8'h33, 1'b0);
    rd_chk(isasr_pkg::OFF_MATCH, 32'h7);
    send(1, 8'h0, 1'b0);
    rd_chk(isasr_pkg::OFF_MATCH, 32'h0);
    send(0, 8'h52, 1'b0);
    send(2, 8'h0, 1'b0);
    rd_chk(isasr_pkg::OFF_MATCH, 32'h0);
    send(0, 8'h52, 1'b1);
    chk_bit(addr_ack, 1'b0);
    send(0, 8'h00, 1'b1);
    chk_bit(bcast, 1'b0);
    rd_chk(isasr_pkg::OFF_MATCH, 32'h0);
    send(0, 8'h00, 1'b0);
    chk_bit(bcast, 1'b1);
    send(1, 8'h0, 1'b0);
    wr(isasr_pkg::OFF_CTRL, 32'h0);
    chk_bit(ack_bit, 1'b0);
    send(0, 8'h52, 1'b0);
    chk_bit(addr_ack, 1'b0);
    send(0, 8'h00, 1'b0);
    chk_bit(bcast, 1'b0);
    $display("test address done");
    send(3, 8'hc3, 1'b0);
    rd_chk(isasr_pkg::OFF_DATA, 32'hc3);
    send(4, 8'h60, 1'b0);
    chk_bit(irq, 1'b1);
    rd_chk(isasr_pkg::OFF_STAT, 32'h60);
    wr(isasr_pkg::OFF_CTRL, 32'hc);
    chk_bit(hold, 1'b1);
    wr(isasr_pkg::OFF_CTRL, 32'h4);
    chk_bit(hold, 1'b0);
    send(4, 8'hf8, 1'b0);
    chk_bit(irq, 1'b0);
    rd_chk(isasr_pkg::OFF_STAT, 32'hf8);
    $display("test status done");
    // Mid-run reset must drop matches and the primary own address
    send(0, 8'h52, 1'b0);
    rd_chk(isasr_pkg::OFF_MATCH, 32'h1);
    @(posedge core_clk_in);
    resetn_in <= 1'b0;
    repeat (2) @(posedge core_clk_in);
    resetn_in <= 1'b1;
    rd_chk(isasr_pkg::OFF_MATCH, 32'h0);
    rd_chk(isasr_pkg::OFF_OWN_PRI, 32'h0);
    $display("test second reset done");
    report_and_stop();
  end

  // Run needs about a hundred cycles; far beyond that means a hang
  initial begin
    repeat (2000) @(posedge core_clk_in);
    err_total++;
    report_and_stop();
  end
endmodule : tb_top
